// *** pkg/dif_pkg.sv ***
// Shared constants and types for the digital input function decoder
package dif_pkg;
  localparam int NUM_TERM = 7;
  localparam int CODE_W = 8;
  // Legal code ranges
  localparam logic [7:0] CODE_MAX_LOW = 8'h4A;
  localparam logic [7:0] CODE_INV_BASE = 8'h64;
  localparam logic [7:0] CODE_MAX_INV = 8'hAE;
  // Function codes
  localparam logic [7:0] FN_2W_FWD = 8'h00;
  localparam logic [7:0] FN_2W_REV = 8'h01;
  localparam logic [7:0] FN_3W = 8'h02;
  localparam logic [7:0] FN_LOCAL = 8'h03;
  localparam logic [7:0] FN_SRC2 = 8'h04;
  localparam logic [7:0] FN_STEP1 = 8'h05;
  localparam logic [7:0] FN_STEP4 = 8'h08;
  localparam logic [7:0] FN_JOG = 8'h09;
  localparam logic [7:0] FN_UP = 8'h0A;
  localparam logic [7:0] FN_DOWN = 8'h0B;
  localparam logic [7:0] FN_UP2 = 8'h0C;
  localparam logic [7:0] FN_DOWN2 = 8'h0D;
  localparam logic [7:0] FN_FORWARD_JOG_CMD = 8'h0E;
  localparam logic [7:0] FN_REVERSE_JOG_CMD = 8'h0F;
  localparam logic [7:0] FN_EF_FIRST = 8'h17;
  localparam logic [7:0] FN_EF_LAST = 8'h26;
  localparam logic [7:0] FN_FAULT_RST = 8'h27;
  localparam logic [7:0] FN_OVERHEAT = 8'h28;
  localparam logic [7:0] FN_PULSE_IN = 8'h4A;
  // Reset codes, terminal 1 in the low byte
  localparam logic [NUM_TERM*8-1:0] TERM_RST_CODES =
    {8'h09, 8'h06, 8'h05, 8'h27, 8'h17, 8'h01, 8'h00};
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RUN_QUAL_TIME_NS = 2000000;
  localparam int RUN_QUAL_CYCLES =
    (RUN_QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LED_HALF_TIME_NS = 250000000;
  localparam int LED_HALF_CYCLES = LED_HALF_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0] POWERUP_SETTLE = 2'h3;
  // Motor data
  localparam logic [15:0] CAP_MAX = 16'hFDE8;
  localparam logic [15:0] CAP_COARSE_DIV = 16'h000A;
  localparam logic [5:0] DEFAULT_POLES = 6'h04;
  localparam logic [31:0] SLIP_SCALE = 32'h0000_0064;
  localparam logic [31:0] SLIP_DIV = 32'h0000_0078;

  typedef struct packed {
    logic fwdRun2w;
    logic revRun2w;
    logic localSel;
    logic srcSel2;
    logic [3:0] speedSel;
    logic jog;
    logic up;
    logic down;
    logic up2;
    logic down2;
    logic forwardJogCmd;
    logic reverseJogCmd;
    logic [15:0] extFault;
    logic faultReset;
    logic overheatAlarmInput;
  } dif_cmd_s;
endpackage

// *** src/dif_sync.sv ***
// Two-stage synchroniser for terminal levels
`timescale 1ns/10ps
`default_nettype none
module dif_sync #(
  parameter int W = 7
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** src/dif_input_decoder.sv ***
// Multi-function digital input decoder with three-wire sequencing
`timescale 1ns/10ps
`default_nettype none
module dif_input_decoder #(
  parameter int RUN_QUAL_CYCLES = dif_pkg::RUN_QUAL_CYCLES,
  parameter int LED_HALF_CYCLES = dif_pkg::LED_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [6:0] termIn,
  input wire logic cfgWrEn,
  input wire logic [2:0] cfgTerm,
  input wire logic [7:0] cfgCode,
  input wire logic powerupRunAccept,
  input wire logic [15:0] motorRatedCapacity,
  input wire logic maxCapAbove300,
  input wire logic closedLoop,
  input wire logic [5:0] motorPoleCount,
  input wire logic [15:0] ratedFreq,
  input wire logic [15:0] ratedSpeed,
  output dif_pkg::dif_cmd_s cmd_q,
  output logic motorRun_q,
  output logic motorReverse_q,
  output logic threeWire_q,
  output logic seventhPulseInput_q,
  output logic inputConfigError_q,
  output logic powerupFault_q,
  output logic ledFlash_q,
  output logic extFaultEvent_q,
  output logic [2:0] extFaultTerm_q,
  output logic [15:0] capDisplay_q,
  output logic capCoarse_q,
  output logic [15:0] motorRatedSlip_q
);
  localparam int NT = dif_pkg::NUM_TERM;

  logic [NT-1:0] syncIn;
  logic [7:0] selCode_q [NT];
  logic [7:0] lowCode [NT];
  logic [NT*8-1:0] selFlat;
  logic [NT-1:0] invSel, termAct, usable, efAct, efPrev_q, efRise;
  logic threeWire, dirAct, fwd2, rev2, upAny, downAny, codeLegal;
  logic runAct, stopAct, runCmd, runQualified, blocked, checkDone_q;
  logic runBlocked_q;
  logic [31:0] qualCnt_q, ledCnt_q, slipProd;
  logic [1:0] settleCnt_q;
  logic [15:0] capStored;
  logic [5:0] poles;
  logic [2:0] efTerm;
  dif_pkg::dif_cmd_s cmdD;

  dif_sync #(.W(NT)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(termIn),
    .q(syncIn)
  );

  // Function selectors, illegal codes dropped
  assign codeLegal = (cfgCode <= dif_pkg::CODE_MAX_LOW) ||
    (cfgCode >= dif_pkg::CODE_INV_BASE &&
     cfgCode <= dif_pkg::CODE_MAX_INV);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NT; i++) begin
        selCode_q[i] <= dif_pkg::TERM_RST_CODES[i*8 +: 8];
      end
    end else if (cfgWrEn && codeLegal && int'(cfgTerm) < NT) begin
      selCode_q[cfgTerm] <= cfgCode;
    end
  end

  for (genvar t = 0; t < NT; t++) begin : g_term
    assign selFlat[t*8 +: 8] = selCode_q[t];
    assign invSel[t] = selCode_q[t] >= dif_pkg::CODE_INV_BASE;
    assign lowCode[t] = invSel[t] ?
      8'(selCode_q[t] - dif_pkg::CODE_INV_BASE) : selCode_q[t];
    assign termAct[t] = syncIn[t] ^ invSel[t];
    assign usable[t] = !(t < 2 && threeWire) &&
      !(t == NT - 1 && lowCode[t] == dif_pkg::FN_PULSE_IN);
    assign efAct[t] = usable[t] && termAct[t] &&
      lowCode[t] >= dif_pkg::FN_EF_FIRST &&
      lowCode[t] <= dif_pkg::FN_EF_LAST;
    assign efRise[t] = efAct[t] && !efPrev_q[t];
  end

  // Three-wire selection on terminals three to seven
  always_comb begin
    threeWire = 1'b0;
    dirAct = 1'b0;
    for (int t = 2; t < NT; t++) begin
      if (lowCode[t] == dif_pkg::FN_3W) begin
        threeWire = 1'b1;
        dirAct = termAct[t];
      end
    end
  end

  // Level function decode
  always_comb begin
    cmdD = '0;
    upAny = 1'b0;
    downAny = 1'b0;
    for (int t = 0; t < NT; t++) begin
      if (usable[t]) begin
        case (lowCode[t])
          dif_pkg::FN_2W_FWD: cmdD.fwdRun2w |= termAct[t];
          dif_pkg::FN_2W_REV: cmdD.revRun2w |= termAct[t];
          dif_pkg::FN_LOCAL: cmdD.localSel |= termAct[t];
          dif_pkg::FN_SRC2: cmdD.srcSel2 |= termAct[t];
          dif_pkg::FN_JOG: cmdD.jog |= termAct[t];
          dif_pkg::FN_UP: begin
            cmdD.up |= termAct[t];
            upAny = 1'b1;
          end
          dif_pkg::FN_DOWN: begin
            cmdD.down |= termAct[t];
            downAny = 1'b1;
          end
          dif_pkg::FN_UP2: cmdD.up2 |= termAct[t];
          dif_pkg::FN_DOWN2: cmdD.down2 |= termAct[t];
          dif_pkg::FN_FORWARD_JOG_CMD: cmdD.forwardJogCmd |= termAct[t];
          dif_pkg::FN_REVERSE_JOG_CMD: cmdD.reverseJogCmd |= termAct[t];
          dif_pkg::FN_FAULT_RST: cmdD.faultReset |= termAct[t];
          dif_pkg::FN_OVERHEAT: cmdD.overheatAlarmInput |= termAct[t];
          default: begin
            if (lowCode[t] >= dif_pkg::FN_STEP1 &&
                lowCode[t] <= dif_pkg::FN_STEP4) begin
              cmdD.speedSel[2'(lowCode[t] - dif_pkg::FN_STEP1)] |=
                termAct[t];
            end
            if (efAct[t]) begin
              cmdD.extFault[4'(lowCode[t] - dif_pkg::FN_EF_FIRST)] = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= '0;
      threeWire_q <= 1'b0;
      seventhPulseInput_q <= 1'b0;
      inputConfigError_q <= 1'b0;
    end else begin
      cmd_q <= cmdD;
      threeWire_q <= threeWire;
      seventhPulseInput_q <= lowCode[NT-1] == dif_pkg::FN_PULSE_IN;
      inputConfigError_q <= upAny ^ downAny;
    end
  end

  // Run qualification and sequencing
  assign runAct = termAct[0];
  assign stopAct = termAct[1];
  assign fwd2 = cmdD.fwdRun2w;
  assign rev2 = cmdD.revRun2w;
  assign runCmd = threeWire ? runAct : (fwd2 | rev2);
  assign runQualified = runAct && qualCnt_q == 32'(RUN_QUAL_CYCLES);
  assign blocked = runBlocked_q || !checkDone_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      qualCnt_q <= '0;
    end else if (!threeWire || !runAct) begin
      qualCnt_q <= '0;
    end else if (qualCnt_q != 32'(RUN_QUAL_CYCLES)) begin
      qualCnt_q <= qualCnt_q + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      motorRun_q <= 1'b0;
    end else if (!threeWire) begin
      motorRun_q <= (fwd2 ^ rev2) && !blocked;
    end else if (!stopAct) begin
      motorRun_q <= 1'b0;
    end else if (runQualified && !blocked) begin
      motorRun_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      motorReverse_q <= 1'b0;
    end else begin
      motorReverse_q <= threeWire ? dirAct : (rev2 && !fwd2);
    end
  end

  // Power-up run check after synchronisers settle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      settleCnt_q <= '0;
      checkDone_q <= 1'b0;
      runBlocked_q <= 1'b0;
      powerupFault_q <= 1'b0;
    end else if (!checkDone_q) begin
      if (settleCnt_q != dif_pkg::POWERUP_SETTLE) begin
        settleCnt_q <= settleCnt_q + 2'h1;
      end else begin
        checkDone_q <= 1'b1;
        runBlocked_q <= runCmd && !powerupRunAccept;
        powerupFault_q <= runCmd && !powerupRunAccept;
      end
    end else if (!runCmd) begin
      runBlocked_q <= 1'b0;
      powerupFault_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ledCnt_q <= '0;
      ledFlash_q <= 1'b0;
    end else if (!powerupFault_q) begin
      ledCnt_q <= '0;
      ledFlash_q <= 1'b0;
    end else if (ledCnt_q == 32'(LED_HALF_CYCLES - 1)) begin
      ledCnt_q <= '0;
      ledFlash_q <= !ledFlash_q;
    end else begin
      ledCnt_q <= ledCnt_q + 32'h1;
    end
  end

  // External fault events, lowest terminal reported
  always_comb begin
    efTerm = 3'h0;
    for (int t = NT - 1; t >= 0; t--) begin
      if (efRise[t]) begin
        efTerm = 3'(t + 1);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      efPrev_q <= '0;
      extFaultEvent_q <= 1'b0;
      extFaultTerm_q <= 3'h0;
    end else begin
      efPrev_q <= efAct;
      extFaultEvent_q <= |efRise;
      if (|efRise) begin
        extFaultTerm_q <= efTerm;
      end
    end
  end

  // Motor data
  assign capStored = motorRatedCapacity > dif_pkg::CAP_MAX ?
    dif_pkg::CAP_MAX : motorRatedCapacity;
  assign poles = closedLoop ? motorPoleCount : dif_pkg::DEFAULT_POLES;
  assign slipProd = (32'(ratedSpeed) * 32'(poles) * dif_pkg::SLIP_SCALE) /
    dif_pkg::SLIP_DIV;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      capDisplay_q <= '0;
      capCoarse_q <= 1'b0;
      motorRatedSlip_q <= '0;
    end else begin
      capDisplay_q <= maxCapAbove300 ?
        capStored / dif_pkg::CAP_COARSE_DIV : capStored;
      capCoarse_q <= maxCapAbove300;
      motorRatedSlip_q <= 32'(ratedFreq) > slipProd ?
        16'(32'(ratedFreq) - slipProd) : 16'h0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_stop_now;
    threeWire && !stopAct |=> !motorRun_q;
  endproperty
  a_stop_now: assert property (p_stop_now)
    else $error("motor kept running with stop open");

  property p_run_qual;
    $rose(motorRun_q) && $past(threeWire) |-> $past(runQualified);
  endproperty
  a_run_qual: assert property (p_run_qual)
    else $error("three-wire run started before qualification");

  property p_direction;
    threeWire |=> motorReverse_q == $past(dirAct);
  endproperty
  a_direction: assert property (p_direction)
    else $error("direction does not follow direction terminal");

  property p_inverted;
    selCode_q[4] == 8'(dif_pkg::CODE_INV_BASE + dif_pkg::FN_FAULT_RST) &&
      !syncIn[4] |=> cmd_q.faultReset;
  endproperty
  a_inverted: assert property (p_inverted)
    else $error("normally closed terminal not inverted");

  property p_legal;
    cfgWrEn && !codeLegal |=> $stable(selFlat);
  endproperty
  a_legal: assert property (p_legal)
    else $error("illegal function code was stored");

  property p_powerup;
    $rose(powerupFault_q) |-> !$past(powerupRunAccept) ##1 !motorRun_q;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("power-up run not blocked correctly");

  property p_cfg_err;
    !upAny && !downAny |=> !inputConfigError_q;
  endproperty
  a_cfg_err: assert property (p_cfg_err)
    else $error("config error without unpaired up or down");

  property p_ef_event;
    extFaultEvent_q |-> extFaultTerm_q != 3'h0 && $past(|efRise);
  endproperty
  a_ef_event: assert property (p_ef_event)
    else $error("external fault event without terminal");

  property p_slip;
    !closedLoop && ratedSpeed == 16'h0 |=> motorRatedSlip_q == $past(ratedFreq);
  endproperty
  a_slip: assert property (p_slip)
    else $error("slip wrong at zero speed");

  property p_pulse_mask;
    lowCode[NT-1] == dif_pkg::FN_PULSE_IN |-> !usable[NT-1] ##1 seventhPulseInput_q;
  endproperty
  a_pulse_mask: assert property (p_pulse_mask)
    else $error("pulse terminal decoded as level");

  c_three_run: cover property (threeWire && $rose(motorRun_q));
  c_powerup: cover property ($rose(powerupFault_q));
  c_ef: cover property (extFaultEvent_q);
  c_cfg_err: cover property ($rose(inputConfigError_q));
endmodule
`default_nettype wire

// *** verification/dif_contacts.sv ***
// Model of the switches and relay contacts wired to the terminals
`timescale 1ns/10ps
`default_nettype none
module dif_contacts (
  input wire logic mclk,
  input wire logic [6:0] closed,
  input wire logic runPress,
  input wire logic [7:0] pressLen,
  output logic [6:0] termIn
);
  logic [7:0] holdCnt;
  initial holdCnt = 8'h00;
  // Run push button held closed for the requested span
  always @(posedge mclk) begin
    if (runPress) holdCnt <= pressLen;
    else if (holdCnt != 8'h00) holdCnt <= holdCnt - 8'h01;
  end
  assign termIn = closed | {6'h00, holdCnt != 8'h00};
endmodule
`default_nettype wire

// *** verification/digital_input_function_decoder_tb.sv ***
// Self-checking bench for the input function decoder
`timescale 1ns/10ps
`default_nettype none
module digital_input_function_decoder_tb;
  logic mclk, arstN, cfgWrEn, runPress, evSeen;
  logic powerupRunAccept, maxCapAbove300, closedLoop;
  logic [6:0] termIn, closedSet;
  logic [2:0] cfgTerm, evTerm;
  logic [7:0] cfgCode, pressLen;
  logic [15:0] motorRatedCapacity, ratedFreq, ratedSpeed;
  logic [5:0] motorPoleCount;
  dif_pkg::dif_cmd_s cmd;
  logic motorRun, motorRev, threeWire, pulseIn, cfgErr, puFault, led;
  logic evPulse, prevLed;
  logic [2:0] evNum;
  logic [15:0] capDisp, slip;
  logic capCoarse;
  int badCount, checksDone, toggles;
  localparam logic [7:0] CODES [18] = '{8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
    8'h17, 8'h1F, 8'h26, 8'h27, 8'h28};

  dif_input_decoder #(.RUN_QUAL_CYCLES(8), .LED_HALF_CYCLES(4))
    u_dif_input_decoder (.mclk(mclk), .arst_n(arstN), .termIn(termIn),
    .cfgWrEn(cfgWrEn), .cfgTerm(cfgTerm), .cfgCode(cfgCode),
    .powerupRunAccept(powerupRunAccept),
    .motorRatedCapacity(motorRatedCapacity),
    .maxCapAbove300(maxCapAbove300), .closedLoop(closedLoop),
    .motorPoleCount(motorPoleCount), .ratedFreq(ratedFreq),
    .ratedSpeed(ratedSpeed), .cmd_q(cmd), .motorRun_q(motorRun),
    .motorReverse_q(motorRev), .threeWire_q(threeWire),
    .seventhPulseInput_q(pulseIn), .inputConfigError_q(cfgErr),
    .powerupFault_q(puFault), .ledFlash_q(led),
    .extFaultEvent_q(evPulse), .extFaultTerm_q(evNum),
    .capDisplay_q(capDisp), .capCoarse_q(capCoarse),
    .motorRatedSlip_q(slip));
  dif_contacts u_dif_contacts (.mclk(mclk), .closed(closedSet),
    .runPress(runPress), .pressLen(pressLen), .termIn(termIn));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (evPulse === 1'b1) begin
      evSeen <= 1'b1;
      evTerm <= evNum;
    end
  end

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic cfg(input logic [2:0] t, input logic [7:0] c);
    @(negedge mclk);
    cfgWrEn = 1'b1;
    cfgTerm = t;
    cfgCode = c;
    @(negedge mclk);
    cfgWrEn = 1'b0;
    cyc(4);
  endtask

  task automatic press(input logic [7:0] n);
    @(negedge mclk);
    runPress = 1'b1;
    pressLen = n;
    @(negedge mclk);
    runPress = 1'b0;
  endtask

  task automatic doReset();
    @(negedge mclk);
    arstN = 1'b0;
    cyc(6);
    arstN = 1'b1;
    cyc(8);
  endtask

  function automatic dif_pkg::dif_cmd_s expOf(input logic [7:0] c);
    dif_pkg::dif_cmd_s e;
    e = '0;
    if (c == 8'h03) e.localSel = 1'b1;
    if (c == 8'h04) e.srcSel2 = 1'b1;
    if (c >= 8'h05 && c <= 8'h08) e.speedSel[c - 8'h05] = 1'b1;
    if (c == 8'h09) e.jog = 1'b1;
    if (c == 8'h0A) e.up = 1'b1;
    if (c == 8'h0B) e.down = 1'b1;
    if (c == 8'h0C) e.up2 = 1'b1;
    if (c == 8'h0D) e.down2 = 1'b1;
    if (c == 8'h0E) e.forwardJogCmd = 1'b1;
    if (c == 8'h0F) e.reverseJogCmd = 1'b1;
    if (c >= 8'h17 && c <= 8'h26) e.extFault[c - 8'h17] = 1'b1;
    if (c == 8'h27) e.faultReset = 1'b1;
    if (c == 8'h28) e.overheatAlarmInput = 1'b1;
    return e;
  endfunction

  initial begin
    #(3000 * 50);
    badCount++;
    wrapUp();
  end

  initial begin
    arstN = 1'b0; cfgWrEn = 1'b0; cfgTerm = 3'h0; cfgCode = 8'h00;
    runPress = 1'b0; pressLen = 8'h00; closedSet = 7'h00; evSeen = 1'b0;
    evTerm = 3'h0; powerupRunAccept = 1'b0; maxCapAbove300 = 1'b0;
    closedLoop = 1'b0; motorPoleCount = 6'h06; ratedFreq = 16'h1770;
    ratedSpeed = 16'h06EA; motorRatedCapacity = 16'h3039;
    doReset();
    chk(34'(threeWire), 34'h0);
    chk(34'(puFault), 34'h0);
    chk(34'(slip), 34'h0064);
    chk(34'(capDisp), 34'h3039);
    closedSet = 7'h7D;
    cyc(5);
    chk(34'(motorRun), 34'h1);
    chk(34'(motorRev), 34'h0);
    chk(34'({cmd.extFault, cmd.faultReset}), 34'h3);
    chk(34'({cmd.speedSel, cmd.jog}), 34'h7);
    chk(34'({evSeen, evTerm}), 34'hB);
    closedSet = 7'h03;
    cyc(5);
    chk(34'({motorRun, cmd.revRun2w}), 34'h1);
    closedSet = 7'h00;
    for (int i = 0; i < 18; i++) begin
      cfg(3'h4, CODES[i]);
      closedSet = 7'h10;
      cyc(5);
      chk(34'(cmd), 34'(expOf(CODES[i])));
      cfg(3'h4, CODES[i] + 8'h64);
      closedSet = 7'h00;
      cyc(5);
      chk(34'(cmd), 34'(expOf(CODES[i])));
    end
    cfg(3'h4, 8'h0A);
    chk(34'(cfgErr), 34'h1);
    cfg(3'h5, 8'h0B);
    chk(34'(cfgErr), 34'h0);
    cfg(3'h4, 8'h05);
    cfg(3'h5, 8'h06);
    cfg(3'h2, 8'h4B);
    closedSet = 7'h04;
    cyc(5);
    chk(34'(cmd.extFault), 34'h1);
    cfg(3'h6, 8'h4A);
    closedSet = 7'h40;
    cyc(5);
    chk(34'({pulseIn, cmd.jog}), 34'h2);
    cfg(3'h6, 8'h09);
    cfg(3'h2, 8'h02);
    chk(34'(threeWire), 34'h1);
    closedSet = 7'h06;
    cyc(4);
    press(8'h05);
    cyc(15);
    chk(34'(motorRun), 34'h0);
    press(8'h0C);
    cyc(5);
    chk(34'(motorRun), 34'h0);
    for (int i = 0; i < 20 && motorRun !== 1'b1; i++) @(negedge mclk);
    chk(34'({motorRun, motorRev}), 34'h3);
    closedSet = 7'h02;
    cyc(5);
    chk(34'({motorRun, motorRev}), 34'h2);
    closedSet = 7'h00;
    @(negedge mclk);
    closedSet = 7'h02;
    cyc(5);
    chk(34'(motorRun), 34'h0);
    ratedSpeed = 16'h0000;
    cyc(3);
    chk(34'(slip), 34'h1770);
    closedLoop = 1'b1;
    ratedSpeed = 16'h0492;
    maxCapAbove300 = 1'b1;
    cyc(5);
    chk(34'(slip), 34'h0096);
    chk(34'({capCoarse, capDisp}), 34'h104D2);
    closedSet = 7'h01;
    doReset();
    chk(34'({puFault, motorRun}), 34'h2);
    toggles = 0;
    for (int i = 0; i < 16; i++) begin
      prevLed = led;
      @(negedge mclk);
      if (led !== prevLed) toggles++;
    end
    chk(34'(toggles), 34'h4);
    closedSet = 7'h00;
    cyc(6);
    chk(34'(puFault), 34'h0);
    powerupRunAccept = 1'b1;
    closedSet = 7'h01;
    doReset();
    chk(34'({puFault, motorRun}), 34'h1);
    wrapUp();
  end
endmodule
`default_nettype wire
